// ==== common/tcc_pkg.sv ====
// Purpose: constants and carriers for the timer clock select and capture
// Assumes: 16-bit register port, byte offsets on word boundaries
// Notes:
// Function
// - Slave mode 000: software bits, update self-clears
// - Internal mode counts clk once enable set
// - Slave mode 111 counts trigger input edges
// - Trigger select 110 picks filtered channel 2
// - Each active edge: one count, trigger flag
// - Inputs resynchronised before reaching the counter
// - Channel 2 own input; filter 0000 bypasses
// - Polarity 00 rising, 10 falling edges
// - External clock 2 enable counts trigger pin
// - Trigger pin filter, edge prescaler, polarity
// - Input: sample, filter, edge select, prescale
// - Reference wave active high, polarity last
// - Bus sees preload; capture goes via shadow
// - Capture latches counter, sets flag, requests
// - Capture while flag set sets overcapture
// - Flag clears by write 0 or read
// - Selection nonzero: input, register read-only
// - Filter 0011 needs eight equal samples
// - Prescaler 00 captures every valid edge
// - Capture generate bit raises channel requests
// - Trigger 101 plus slave 100 resets counter
// - Count enable follows enable bit one cycle
package tcc_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam logic [AW-1:0] OFF_CR1 = 8'h00;
    localparam logic [AW-1:0] OFF_SMCR = 8'h08;
    localparam logic [AW-1:0] OFF_DIER = 8'h0C;
    localparam logic [AW-1:0] OFF_SR = 8'h10;
    localparam logic [AW-1:0] OFF_EGR = 8'h14;
    localparam logic [AW-1:0] OFF_CCMR1 = 8'h18;
    localparam logic [AW-1:0] OFF_CCER = 8'h20;
    localparam logic [AW-1:0] OFF_CNT = 8'h24;
    localparam logic [1:0][AW-1:0] OFF_CCR = {8'h38, 8'h34};
    localparam int CEN_B = 0;
    localparam int SMS_L = 0;
    localparam int TS_L = 4;
    localparam int ETF_L = 8;
    localparam int EXT_TRIGGER_PRESCALER_L = 12;
    localparam int ECE_B = 14;
    localparam int ETP_B = 15;
    localparam int CCIE_L = 1;
    localparam int TIE_B = 6;
    localparam int CCDE_L = 9;
    localparam int CCIF_L = 1;
    localparam int TIF_B = 6;
    localparam int CCOF_L = 9;
    localparam int UG_B = 0;
    localparam int CCG_L = 1;
    localparam int TG_B = 6;
    localparam int CCS_L = 0;
    localparam int ICPS_L = 2;
    localparam int ICF_L = 4;
    localparam int CCMR_STEP = 8;
    localparam int CCE_L = 0;
    localparam int CCP_L = 1;
    localparam int CCNP_L = 3;
    localparam int CCER_STEP = 4;
    localparam logic [2:0] SMS_OFF = 3'h0;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_EXT1 = 3'h7;
    localparam logic [2:0] TS_CH1 = 3'h5;
    localparam logic [2:0] TS_CH2 = 3'h6;
    localparam logic [1:0] CCS_OUT = 2'h0;
    localparam logic [1:0] CCS_OWN = 2'h1;
    localparam logic [1:0] CCS_OTHER = 2'h2;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [15:0] RST_VAL = 16'h0000;

    // Samples needed before a new input level is believed
    function automatic logic [4:0] tcc_flt_len(input logic [3:0] f);
        case (f)
            4'h0: tcc_flt_len = 5'h01;
            4'h1: tcc_flt_len = 5'h02;
            4'h2: tcc_flt_len = 5'h04;
            default: tcc_flt_len = 5'h08;
        endcase
    endfunction

    typedef struct packed {
        logic rd;
        logic wr;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } tcc_bus_t;

    typedef struct packed {
        logic [1:0] cc_irq;
        logic [1:0] cc_dma;
        logic trig_irq;
    } tcc_req_t;
endpackage

// ==== rtl/tcc_in_filt.sv ====
// Purpose: resynchronise one input pin and filter its level
// Assumes: filter sampling clock is clk
// Notes: output changes only after the chosen run of equal samples
`timescale 1ns/100ps
module tcc_in_filt #(
    parameter int CW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and filter setting
    input wire logic pin,
    input wire logic [3:0] flt_sel,
    // Filtered level
    output logic filt
);
    import tcc_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic filt;
        logic [CW-1:0] cnt;
    } tcc_flt_st_t;

    tcc_flt_st_t s_r;
    tcc_flt_st_t s_nxt;

    if (CW < 4) begin : g_chk
        $error("tcc_in_filt: CW must hold a count of eight");
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = pin;
        s_nxt.sync2 = s_r.sync1;
        if (s_r.sync2 == s_r.filt) begin
            s_nxt.cnt = '0;
        end else if (int'(s_r.cnt) + 1 >= int'(tcc_flt_len(flt_sel))) begin
            s_nxt.filt = s_r.sync2;
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign filt = s_r.filt;
endmodule

// ==== rtl/tcc_top.sv ====
// Purpose: counter clock selection and two input capture channels
// Assumes: pins synchronous to clk; register port never waits
// Notes: counter prescaler ratio fixed at one; no internal triggers
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module tcc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input tcc_pkg::tcc_bus_t bus,
    output logic [tcc_pkg::DW-1:0] rdata,
    // Pins
    input wire logic [1:0] ch_pin,
    input wire logic ext_trigger_pin,
    // Requests and channel outputs
    output tcc_pkg::tcc_req_t req,
    output logic [1:0] ch_out
);
    import tcc_pkg::*;

    typedef struct packed {
        logic counter_enable_bit;
        logic internal_count_enable;
        logic [2:0] slave_mode_select;
        logic [2:0] ts;
        logic [3:0] ext_trigger_filter;
        logic [1:0] ext_trigger_prescaler;
        logic ece;
        logic ext_trigger_polarity;
        logic tie;
        logic [1:0] ccie;
        logic [1:0] ccde;
        logic trigger_interrupt_flag;
        logic [1:0] ccif;
        logic [1:0] ccof;
        logic [1:0][1:0] ccs;
        logic [1:0][1:0] icps;
        logic [1:0][3:0] icf;
        logic [1:0] cce;
        logic [1:0] ccp;
        logic [1:0] ccnp;
        logic [15:0] cnt;
        logic [1:0][15:0] pre;
        logic [1:0][15:0] sh;
        logic [1:0][2:0] pcnt;
        logic [2:0] ediv;
        logic [1:0] tf_q;
        logic etr_q;
        logic [15:0] rdata;
        tcc_req_t req;
        logic [1:0] out;
    } tcc_state_t;

    tcc_state_t s_r;
    tcc_state_t s_nxt;

    logic [1:0] tf;
    logic etr_lvl;
    logic [1:0] ic_edge;
    logic [1:0] cap_ev;
    logic [1:0] r_ccr;
    logic [1:0] w_ccr;
    logic ti1_trg;
    logic ti2_trg;
    logic trig;
    logic etr_edge;
    logic etr_tick;
    logic tick;
    logic w_cr1;
    logic w_smcr;
    logic w_dier;
    logic w_sr;
    logic w_egr;
    logic w_ccmr;
    logic w_ccer;
    logic w_cnt;
    logic [15:0] wd;

    // Edge detector with polarity pair: 00 rising, 10 falling, 11 both
    function automatic logic edg(input logic cur, input logic prev,
                                 input logic p, input logic np);
        if (p && np) begin
            edg = cur ^ prev;
        end else if (p) begin
            edg = prev & ~cur;
        end else begin
            edg = cur & ~prev;
        end
    endfunction

    function automatic logic [2:0] psc_max(input logic [1:0] sel);
        psc_max = 3'((4'h1 << sel) - 4'h1);
    endfunction

    assign wd = bus.wdata;
    assign w_cr1 = bus.wr && bus.addr == OFF_CR1;
    assign w_smcr = bus.wr && bus.addr == OFF_SMCR;
    assign w_dier = bus.wr && bus.addr == OFF_DIER;
    assign w_sr = bus.wr && bus.addr == OFF_SR;
    assign w_egr = bus.wr && bus.addr == OFF_EGR;
    assign w_ccmr = bus.wr && bus.addr == OFF_CCMR1;
    assign w_ccer = bus.wr && bus.addr == OFF_CCER;
    assign w_cnt = bus.wr && bus.addr == OFF_CNT;

    // Per channel input stage: sync and filter, then mapping and edges
    for (genvar k = 0; k < 2; k++) begin : g_ch
        localparam int O = 1 - k;
        tcc_in_filt #(.CW(4)) u_flt (
            .clk(clk),
            .rst(rst),
            .pin(ch_pin[k]),
            .flt_sel(s_r.icf[k]),
            .filt(tf[k])
        );
        assign ic_edge[k] = (s_r.ccs[k] == CCS_OWN) ?
            edg(tf[k], s_r.tf_q[k], s_r.ccp[k], s_r.ccnp[k]) :
            (s_r.ccs[k] == CCS_OTHER) ?
            edg(tf[O], s_r.tf_q[O], s_r.ccp[k], s_r.ccnp[k]) :
            1'b0;
        // Prescaler counts valid edges; capture needs the channel enabled
        assign cap_ev[k] = ic_edge[k] && s_r.cce[k] &&
            s_r.pcnt[k] == psc_max(s_r.icps[k]);
        assign r_ccr[k] = bus.rd && bus.addr == OFF_CCR[k];
        assign w_ccr[k] = bus.wr && bus.addr == OFF_CCR[k];
    end

    tcc_in_filt #(.CW(4)) u_etr_flt (
        .clk(clk),
        .rst(rst),
        .pin(ext_trigger_pin),
        .flt_sel(s_r.ext_trigger_filter),
        .filt(etr_lvl)
    );

    assign ti1_trg = edg(tf[0], s_r.tf_q[0], s_r.ccp[0], s_r.ccnp[0]);
    assign ti2_trg = edg(tf[1], s_r.tf_q[1], s_r.ccp[1], s_r.ccnp[1]);
    assign trig = (s_r.ts == TS_CH1) ? ti1_trg :
                  (s_r.ts == TS_CH2) ? ti2_trg : 1'b0;
    assign etr_edge = (etr_lvl ^ s_r.ext_trigger_polarity) & ~(s_r.etr_q ^ s_r.ext_trigger_polarity);
    assign etr_tick = etr_edge && s_r.ediv == psc_max(s_r.ext_trigger_prescaler);
    // Mode 1 wins over mode 2 when both are set
    assign tick = (s_r.slave_mode_select == SMS_EXT1) ? trig :
                  s_r.ece ? etr_tick : 1'b1;

    always_comb begin
        logic upd;
        logic [15:0] img;
        upd = 1'b0;
        img = '0;
        s_nxt = s_r;
        s_nxt.internal_count_enable = s_r.counter_enable_bit;
        s_nxt.tf_q = tf;
        s_nxt.etr_q = etr_lvl;
        if (w_cr1) begin
            s_nxt.counter_enable_bit = wd[CEN_B];
        end
        if (w_smcr) begin
            s_nxt.slave_mode_select = wd[SMS_L +: 3];
            s_nxt.ts = wd[TS_L +: 3];
            s_nxt.ext_trigger_filter = wd[ETF_L +: 4];
            s_nxt.ext_trigger_prescaler = wd[EXT_TRIGGER_PRESCALER_L +: 2];
            s_nxt.ece = wd[ECE_B];
            s_nxt.ext_trigger_polarity = wd[ETP_B];
        end
        if (w_dier) begin
            s_nxt.ccie = wd[CCIE_L +: 2];
            s_nxt.ccde = wd[CCDE_L +: 2];
            s_nxt.tie = wd[TIE_B];
        end
        if (etr_edge) begin
            s_nxt.ediv = etr_tick ? 3'h0 : s_r.ediv + 3'h1;
        end
        // Update generation is a pulse; nothing of it is stored
        if (w_egr && wd[UG_B]) begin
            s_nxt.cnt = '0;
            s_nxt.ediv = 3'h0;
            upd = 1'b1;
        end else if (s_r.slave_mode_select == SMS_RESET && trig) begin
            s_nxt.cnt = '0;
            upd = 1'b1;
        end else if (w_cnt) begin
            s_nxt.cnt = wd;
        end else if (s_r.internal_count_enable && tick) begin
            s_nxt.cnt = s_r.cnt + 16'h1;
            upd = s_r.cnt == CNT_TOP;
        end
        // Clear first so that a same-cycle set wins
        if (w_sr && !wd[TIF_B]) begin
            s_nxt.trigger_interrupt_flag = 1'b0;
        end
        if ((trig && s_r.slave_mode_select != SMS_OFF) || (w_egr && wd[TG_B])) begin
            s_nxt.trigger_interrupt_flag = 1'b1;
        end
        s_nxt.req.cc_dma = 2'h0;
        for (int k = 0; k < 2; k++) begin
            if (w_ccmr) begin
                s_nxt.ccs[k] = wd[k*CCMR_STEP+CCS_L +: 2];
                s_nxt.icps[k] = wd[k*CCMR_STEP+ICPS_L +: 2];
                s_nxt.icf[k] = wd[k*CCMR_STEP+ICF_L +: 4];
            end
            if (w_ccer) begin
                s_nxt.cce[k] = wd[k*CCER_STEP+CCE_L];
                s_nxt.ccp[k] = wd[k*CCER_STEP+CCP_L];
                s_nxt.ccnp[k] = wd[k*CCER_STEP+CCNP_L];
            end
            if ((w_sr && !wd[CCIF_L+k]) || r_ccr[k]) begin
                s_nxt.ccif[k] = 1'b0;
            end
            if (w_sr && !wd[CCOF_L+k]) begin
                s_nxt.ccof[k] = 1'b0;
            end
            if (!s_r.cce[k] || s_r.ccs[k] == CCS_OUT) begin
                s_nxt.pcnt[k] = 3'h0;
            end else if (ic_edge[k]) begin
                s_nxt.pcnt[k] = cap_ev[k] ? 3'h0 : s_r.pcnt[k] + 3'h1;
            end
            if (s_r.ccs[k] != CCS_OUT) begin
                // Preload trails shadow by one cycle in input mode
                s_nxt.pre[k] = s_r.sh[k];
                if (cap_ev[k]) begin
                    s_nxt.sh[k] = s_r.cnt;
                    s_nxt.ccif[k] = 1'b1;
                    s_nxt.req.cc_dma[k] = s_r.ccde[k];
                    if (s_r.ccif[k]) begin
                        s_nxt.ccof[k] = 1'b1;
                    end
                end
            end else begin
                if (w_ccr[k]) begin
                    s_nxt.pre[k] = wd;
                end
                if (upd) begin
                    s_nxt.sh[k] = s_r.pre[k];
                end
            end
            if (w_egr && wd[CCG_L+k]) begin
                s_nxt.ccif[k] = 1'b1;
                s_nxt.req.cc_dma[k] = s_r.ccde[k];
            end
            // Reference is active high; polarity only at the pin
            s_nxt.out[k] = (s_r.ccs[k] == CCS_OUT) && s_r.cce[k] &&
                ((s_r.cnt < s_r.sh[k]) ^ s_r.ccp[k]);
        end
        s_nxt.req.cc_irq = s_nxt.ccif & s_nxt.ccie;
        s_nxt.req.trig_irq = s_nxt.trigger_interrupt_flag & s_nxt.tie;
        if (bus.rd) begin
            case (bus.addr)
                OFF_CR1: img[CEN_B] = s_r.counter_enable_bit;
                OFF_SMCR: begin
                    img[SMS_L +: 3] = s_r.slave_mode_select;
                    img[TS_L +: 3] = s_r.ts;
                    img[ETF_L +: 4] = s_r.ext_trigger_filter;
                    img[EXT_TRIGGER_PRESCALER_L +: 2] = s_r.ext_trigger_prescaler;
                    img[ECE_B] = s_r.ece;
                    img[ETP_B] = s_r.ext_trigger_polarity;
                end
                OFF_DIER: begin
                    img[CCIE_L +: 2] = s_r.ccie;
                    img[CCDE_L +: 2] = s_r.ccde;
                    img[TIE_B] = s_r.tie;
                end
                OFF_SR: begin
                    img[CCIF_L +: 2] = s_r.ccif;
                    img[CCOF_L +: 2] = s_r.ccof;
                    img[TIF_B] = s_r.trigger_interrupt_flag;
                end
                OFF_CCMR1: begin
                    for (int k = 0; k < 2; k++) begin
                        img[k*CCMR_STEP+CCS_L +: 2] = s_r.ccs[k];
                        img[k*CCMR_STEP+ICPS_L +: 2] = s_r.icps[k];
                        img[k*CCMR_STEP+ICF_L +: 4] = s_r.icf[k];
                    end
                end
                OFF_CCER: begin
                    for (int k = 0; k < 2; k++) begin
                        img[k*CCER_STEP+CCE_L] = s_r.cce[k];
                        img[k*CCER_STEP+CCP_L] = s_r.ccp[k];
                        img[k*CCER_STEP+CCNP_L] = s_r.ccnp[k];
                    end
                end
                OFF_CNT: img = s_r.cnt;
                OFF_CCR[0]: img = s_r.pre[0];
                OFF_CCR[1]: img = s_r.pre[1];
                default: img = RST_VAL;
            endcase
        end
        s_nxt.rdata = img;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign req = s_r.req;
    assign ch_out = s_r.out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence cap0_s;
        cap_ev[0] && s_r.ccs[0] != CCS_OUT && !w_ccmr;
    endsequence

    sequence hold_in_s;
        s_r.ccs[0] != CCS_OUT [*2];
    endsequence

    en_lag_a: assert property ($rose(s_r.counter_enable_bit) |=> s_r.internal_count_enable || !s_r.counter_enable_bit)
        else $error("count enable did not follow enable bit");
    en_cause_a: assert property (s_r.internal_count_enable |-> $past(s_r.counter_enable_bit))
        else $error("count enable without prior enable bit");
    ug_clear_a: assert property (w_egr && wd[UG_B] |=> s_r.cnt == 16'h0)
        else $error("update generate did not clear counter");
    int_count_a: assert property (s_r.internal_count_enable && s_r.slave_mode_select == SMS_OFF && !s_r.ece
        && !bus.wr |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h1))
        else $error("internal clock did not advance counter");
    ext1_count_a: assert property (s_r.internal_count_enable && s_r.slave_mode_select == SMS_EXT1 && trig
        && !bus.wr |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h1) && s_r.trigger_interrupt_flag)
        else $error("trigger edge did not count once and flag");
    ext1_idle_a: assert property (s_r.slave_mode_select == SMS_EXT1 && !trig && !bus.wr
        |=> $stable(s_r.cnt))
        else $error("counter moved without a trigger edge");
    tif_hold_a: assert property (s_r.trigger_interrupt_flag && !w_sr |=> s_r.trigger_interrupt_flag)
        else $error("trigger flag dropped without a write");
    reset_mode_a: assert property (s_r.slave_mode_select == SMS_RESET && trig && !bus.wr
        |=> s_r.cnt == 16'h0)
        else $error("reset mode did not clear counter");
    capture_a: assert property (cap_ev[0] && s_r.ccs[0] != CCS_OUT
        |=> s_r.sh[0] == $past(s_r.cnt) && s_r.ccif[0])
        else $error("capture did not latch counter and flag");
    cap_copy_a: assert property (cap0_s ##0 hold_in_s
        |=> s_r.pre[0] == $past(s_r.cnt, 2))
        else $error("capture not copied to preload");
    overcap_a: assert property (cap_ev[0] && s_r.ccif[0] && s_r.ccs[0] != 2'h0
        |=> s_r.ccof[0])
        else $error("overcapture flag not set");
    read_clear_a: assert property (r_ccr[0] && !cap_ev[0]
        && !(w_egr && wd[CCG_L]) |=> !s_r.ccif[0])
        else $error("capture read did not clear flag");
    ccr_ro_a: assert property (w_ccr[0] && s_r.ccs[0] != CCS_OUT && !cap_ev[0]
        |=> s_r.pre[0] == $past(s_r.sh[0]) && $stable(s_r.sh[0]))
        else $error("input-mode capture register was written");
    ccg_req_a: assert property (w_egr && wd[CCG_L] && s_r.ccde[0]
        |=> s_r.ccif[0] && s_r.req.cc_dma[0])
        else $error("capture generate raised no request");
endmodule

// ==== tb/tcc_pin_model.sv ====
// Purpose: far side of the block: channel pins and external trigger pin
// Assumes: pins change only by non-blocking assignment at a rising edge
// Notes: pins idle low; widths are counted in clock cycles
`timescale 1ns/100ps
module tcc_pin_model (
    // Clock
    input wire logic clk,
    // Pins driven into the block
    output logic [1:0] ch_pin,
    output logic ext_trigger_pin
);
    initial begin
        ch_pin = 2'h0;
        ext_trigger_pin = 1'b0;
    end

    // Index 0 and 1 are channel inputs, 2 is the trigger pin
    task automatic drive(input int pin, input logic v);
        if (pin == 2) begin
            ext_trigger_pin <= v;
        end else begin
            ch_pin[pin[0]] <= v;
        end
    endtask

    // Short high times model glitches that a filter must swallow
    task automatic pulse(input int pin, input int n, input int hi,
                         input int lo);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            drive(pin, 1'b1);
            repeat (hi) @(posedge clk);
            drive(pin, 1'b0);
            repeat (lo - 1) @(posedge clk);
        end
    endtask
endmodule

// ==== tb/tcc_top_tb.sv ====
// Purpose: self-checking bench for clock selection and input capture
// Assumes: read data stand only in the cycle after the read strobe
// Notes: pin waits cover the two sync flops and the longest filter
`timescale 1ns/100ps
module tcc_top_tb;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tcc_bus_t bus = '0;
    logic [DW-1:0] rdata;
    tcc_req_t req;
    logic [1:0] ch_out;
    logic [1:0] ch_pin;
    logic ext_trigger_pin;
    int err_count = 0;
    int n_compared = 0;
    int dma_n = 0;
    int dma1_n = 0;
    logic [AW-1:0] offs [0:10] = '{OFF_CR1, OFF_SMCR, OFF_DIER, OFF_SR,
        OFF_EGR, OFF_CCMR1, OFF_CCER, OFF_CNT, OFF_CCR[0], OFF_CCR[1],
        8'h04};

    always #2.5 clk = ~clk;

    tcc_top DUT (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .ch_pin(ch_pin), .ext_trigger_pin(ext_trigger_pin), .req(req),
        .ch_out(ch_out));
    tcc_pin_model pins (.clk(clk), .ch_pin(ch_pin),
        .ext_trigger_pin(ext_trigger_pin));

    // Dma requests are one-cycle pulses, so they are counted
    always @(posedge clk) begin
        if (req.cc_dma[0] === 1'b1) begin
            dma_n <= dma_n + 1;
        end
        if (req.cc_dma[1] === 1'b1) begin
            dma1_n <= dma1_n + 1;
        end
    end

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The tests take under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        look(0);
        chk({9'h0, req, ch_out}, 16'h0000);
        foreach (offs[i]) begin
            rc(offs[i], 16'h0000);
        end
        // Internal clock: enable bit, one cycle later counting
        wr(OFF_CR1, 16'h0001);
        rc(OFF_CNT, 16'h0000);
        rc(OFF_CNT, 16'h0002);
        rc(OFF_CNT, 16'h0004);
        wr(OFF_CR1, 16'h0000);
        wr(OFF_EGR, 16'h0001);
        rc(OFF_EGR, 16'h0000);
        rc(OFF_CNT, 16'h0000);
        // External clock mode 1 from channel 2
        wr(OFF_CCMR1, 16'h0100);
        wr(OFF_SMCR, 16'h0067);
        wr(OFF_DIER, 16'h0040);
        wr(OFF_CR1, 16'h0001);
        pins.pulse(1, 5, 4, 4);
        look(16);
        rc(OFF_CNT, 16'h0005);
        chk({15'h0, req.trig_irq}, 16'h0001);
        rc(OFF_SR, 16'h0040);
        wr(OFF_SR, 16'h0000);
        look(2);
        chk({15'h0, req.trig_irq}, 16'h0000);
        wr(OFF_DIER, 16'h0000);
        pins.pulse(1, 1, 4, 4);
        look(16);
        chk({15'h0, req.trig_irq}, 16'h0000);
        rc(OFF_SR, 16'h0040);
        wr(OFF_CCMR1, 16'h3100);
        wr(OFF_EGR, 16'h0001);
        pins.pulse(1, 3, 4, 12);
        pins.pulse(1, 2, 12, 12);
        look(16);
        rc(OFF_CNT, 16'h0002);
        wr(OFF_CCMR1, 16'h0100);
        wr(OFF_CCER, 16'h0020);
        wr(OFF_EGR, 16'h0001);
        pins.pulse(1, 3, 4, 4);
        look(16);
        rc(OFF_CNT, 16'h0003);
        // External clock mode 2, every edge prescaler ratio
        for (int p = 0; p < 4; p++) begin
            wr(OFF_SMCR, 16'h4000 | DW'(p << 12));
            wr(OFF_EGR, 16'h0001);
            pins.pulse(2, 8, 3, 3);
            look(12);
            rc(OFF_CNT, DW'(8 >> p));
        end
        // Capture on channel 1 with counter held
        wr(OFF_SMCR, 16'h0000);
        wr(OFF_CR1, 16'h0000);
        wr(OFF_CCMR1, 16'h0001);
        wr(OFF_CCER, 16'h0001);
        wr(OFF_DIER, 16'h0202);
        wr(OFF_SR, 16'h0000);
        wr(OFF_CNT, 16'h1234);
        pins.pulse(0, 1, 4, 4);
        look(12);
        chk({14'h0, req.cc_irq}, 16'h0001);
        chk(DW'(dma_n), 16'h0001);
        rc(OFF_SR, 16'h0002);
        rc(OFF_CCR[0], 16'h1234);
        look(2);
        chk({14'h0, req.cc_irq}, 16'h0000);
        wr(OFF_CCR[0], 16'h5555);
        rc(OFF_CCR[0], 16'h1234);
        wr(OFF_CNT, 16'h00AB);
        pins.pulse(0, 2, 4, 4);
        look(12);
        chk({14'h0, req.cc_irq}, 16'h0001);
        rc(OFF_CCR[0], 16'h00AB);
        rc(OFF_SR, 16'h0200);
        wr(OFF_SR, 16'h0000);
        rc(OFF_SR, 16'h0000);
        chk(DW'(dma_n), 16'h0003);
        wr(OFF_EGR, 16'h0002);
        look(3);
        chk({14'h0, req.cc_irq}, 16'h0001);
        chk(DW'(dma_n), 16'h0004);
        // Channel 2 as output: reference high while counter below
        wr(OFF_CCR[1], 16'h0010);
        wr(OFF_CNT, 16'h0000);
        wr(OFF_EGR, 16'h0001);
        rc(OFF_CCR[1], 16'h0010);
        wr(OFF_CCER, 16'h0011);
        look(2);
        chk({14'h0, ch_out}, 16'h0002);
        wr(OFF_CCER, 16'h0031);
        look(2);
        chk({14'h0, ch_out}, 16'h0000);
        // Period and high time on input 1, counter reset by trigger
        wr(OFF_CCMR1, 16'h0201);
        wr(OFF_SMCR, 16'h0054);
        wr(OFF_DIER, 16'h0400);
        wr(OFF_CR1, 16'h0001);
        pins.pulse(0, 3, 20, 30);
        look(12);
        rc(OFF_CCR[0], 16'h0031);
        rc(OFF_CCR[1], 16'h0013);
        chk(DW'(dma1_n), 16'h0003);
        close_out();
    end
endmodule
